/* design/swdf_top.sv */
// Supervisor watchdog with active-low reset and failover flag outputs.
// Assumes cfg is static while running and comes from the clk domain.
// Contract
// - A zero watchdog period disables kick fault detection and reporting.
// - Timeout variant: kick edges must come within one period, else reset.
// - Watchdog counter clears on every kick falling edge and during reset.
// - Three consecutive missed periods assert the failover flag.
// - Windowed variant: early or late kick drives reset low one timeout.
// - Windowed variant: counter idles in reset, counts after release.
// - Failover flag stays low until three consecutive good kick edges.
// - Failover flag is never asserted while the supply monitor is low.
// - Reset asserts whenever the supply monitor reports below threshold.
// - Reset holds while monitor is low, then one reset period more.
// - Each kick fault asserts reset for exactly one reset period.
// - Closed window is 50 or 75 percent of the watchdog period.
// - Gated variant: first period after enable rises lasts eight periods.
// - Kick pulses under 1 us are ignored, above 6.5 us recognised.
// - Watchdog counter restarts from zero when reset releases.
`timescale 1ns/1ps
module swdf_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic kick_in,
  input wire logic supply_monitor_in,
  input wire logic wd_enable_in,
  input wire swdf_pkg::swdf_cfg_t cfg,
  output logic reset_n,
  output logic failover_n
);

  function automatic logic [swdf_pkg::WCNT_W-1:0] win_closed(
    input logic [swdf_pkg::CNT_W-1:0] per,
    input logic w75
  );
    logic [swdf_pkg::CNT_W-1:0] half, quarter;
    half = per >> 1;
    quarter = per >> 2;
    // The 75 percent window is built as period less a quarter.
    if (w75)
      win_closed = {3'h0, per - quarter};
    else
      win_closed = {3'h0, half};
  endfunction

  logic kick_fall;
  logic mon_s1_q, mon_ok, en_s1_q, en_s2_q, en_prev_q;
  swdf_pkg::swdf_state_t state_q, state_d;
  logic [swdf_pkg::CNT_W-1:0] rcnt_q, rcnt_d;
  logic [swdf_pkg::WCNT_W-1:0] wcnt_q, wcnt_d, wd_limit, closed;
  logic [1:0] miss_q, miss_d, good_q, good_d;
  logic fail_q, fail_d, long_q, long_d;
  logic reset_n_q, failover_n_q;
  logic wd_en, en_rise, timeout_hit, early_kick, rto_done;

  swdf_kick_filter u_kick (
    .clk(clk),
    .reset(reset),
    .kick_in(kick_in),
    .kick_fall(kick_fall)
  );

  // Monitor and enable pins are asynchronous, so both go through two flops.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mon_s1_q <= 1'b0;
      mon_ok <= 1'b0;
      en_s1_q <= 1'b0;
      en_s2_q <= 1'b0;
      en_prev_q <= 1'b0;
    end
    else
    begin
      mon_s1_q <= supply_monitor_in;
      mon_ok <= mon_s1_q;
      en_s1_q <= wd_enable_in;
      en_s2_q <= en_s1_q;
      en_prev_q <= en_s2_q;
    end
  end

  assign en_rise = cfg.gated & en_s2_q & ~en_prev_q;
  assign wd_en = (cfg.wd_period != '0) & (~cfg.gated | en_s2_q);
  assign wd_limit = long_q ? {cfg.wd_period, 3'h0}
                           : {3'h0, cfg.wd_period};
  assign closed = win_closed(cfg.wd_period, cfg.win_75);
  // A rising enable restarts the count, so it must never count as a miss.
  assign timeout_hit = (state_q == swdf_pkg::ST_RUN) & wd_en & ~kick_fall
                       & ~en_rise
                       & (wcnt_q >= wd_limit - 27'h1);
  assign early_kick = cfg.windowed & (wcnt_q < closed);
  assign rto_done = ({1'b0, rcnt_q} + 25'h1)
                    >= {1'b0, cfg.rst_period};

  always_comb
  begin
    state_d = state_q;
    rcnt_d = '0;
    wcnt_d = '0;
    miss_d = miss_q;
    good_d = good_q;
    fail_d = fail_q;
    long_d = long_q;
    if (en_rise)
    begin
      long_d = 1'b1;
    end
    case (state_q)
      swdf_pkg::ST_HOLD:
      begin
        if (mon_ok)
        begin
          state_d = swdf_pkg::ST_RTO;
        end
      end
      swdf_pkg::ST_RTO:
      begin
        if (!mon_ok)
        begin
          state_d = swdf_pkg::ST_HOLD;
        end
        else if (rto_done)
        begin
          state_d = swdf_pkg::ST_RUN;
        end
        else
        begin
          rcnt_d = rcnt_q + 24'h1;
        end
      end
      swdf_pkg::ST_RUN:
      begin
        if (!mon_ok)
        begin
          state_d = swdf_pkg::ST_HOLD;
        end
        else if (!wd_en || en_rise)
        begin
          wcnt_d = '0;
        end
        else if (kick_fall && early_kick)
        begin
          state_d = swdf_pkg::ST_RTO;
          good_d = swdf_pkg::CNT2_RST;
        end
        else if (kick_fall)
        begin
          long_d = 1'b0;
          miss_d = swdf_pkg::CNT2_RST;
          if (fail_q)
          begin
            if (good_q == swdf_pkg::GOOD_LIMIT_M1)
            begin
              fail_d = 1'b0;
              good_d = swdf_pkg::CNT2_RST;
            end
            else
            begin
              good_d = good_q + 2'h1;
            end
          end
        end
        else if (timeout_hit)
        begin
          state_d = swdf_pkg::ST_RTO;
          good_d = swdf_pkg::CNT2_RST;
          if (miss_q == swdf_pkg::MISS_LIMIT_M1)
          begin
            fail_d = 1'b1;
          end
          else
          begin
            miss_d = miss_q + 2'h1;
          end
        end
        else
        begin
          wcnt_d = wcnt_q + 27'h1;
        end
      end
      default:
      begin
        state_d = swdf_pkg::ST_HOLD;
      end
    endcase
  end

  // Outputs are registered from the next state so they never glitch.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= swdf_pkg::ST_HOLD;
      rcnt_q <= '0;
      wcnt_q <= '0;
      miss_q <= swdf_pkg::CNT2_RST;
      good_q <= swdf_pkg::CNT2_RST;
      fail_q <= 1'b0;
      long_q <= 1'b0;
      reset_n_q <= swdf_pkg::RESET_N_RST;
      failover_n_q <= swdf_pkg::FAILOVER_N_RST;
    end
    else
    begin
      state_q <= state_d;
      rcnt_q <= rcnt_d;
      wcnt_q <= wcnt_d;
      miss_q <= miss_d;
      good_q <= good_d;
      fail_q <= fail_d;
      long_q <= long_d;
      reset_n_q <= (state_d == swdf_pkg::ST_RUN);
      failover_n_q <= ~(fail_d & mon_ok);
    end
  end

  assign reset_n = reset_n_q;
  assign failover_n = failover_n_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_disabled_no_fault: assert property (
    (state_q == swdf_pkg::ST_RUN && cfg.wd_period == '0 && mon_ok)
    |=> state_q == swdf_pkg::ST_RUN)
    else $error("Fault seen with watchdog disabled.");

  a_timeout_resets: assert property (
    timeout_hit && mon_ok |=> !reset_n_q && rcnt_q == '0)
    else $error("Missed kick did not start a reset.");

  a_kick_clears: assert property (
    kick_fall |=> wcnt_q == '0)
    else $error("Watchdog counter not cleared by kick.");

  a_miss_sets_flag: assert property (
    timeout_hit && mon_ok && miss_q == swdf_pkg::MISS_LIMIT_M1
    |=> fail_q ##1 !failover_n_q || !mon_ok)
    else $error("Failover flag missing after three timeouts.");

  a_early_kick_rst: assert property (
    state_q == swdf_pkg::ST_RUN && mon_ok && wd_en && !en_rise
    && kick_fall && early_kick |=> state_q == swdf_pkg::ST_RTO)
    else $error("Early kick not punished by reset.");

  a_idle_in_reset: assert property (
    state_q != swdf_pkg::ST_RUN |-> wcnt_q == '0)
    else $error("Watchdog counter moved during reset.");

  a_flag_release: assert property (
    $fell(fail_q) |-> $past(good_q) == swdf_pkg::GOOD_LIMIT_M1)
    else $error("Failover released before three good kicks.");

  a_no_flag_low: assert property (
    !mon_ok |=> failover_n_q)
    else $error("Failover asserted with supply low.");

  a_supply_reset: assert property (
    !mon_ok |=> !reset_n_q)
    else $error("Reset not asserted with supply low.");

  a_rto_hold: assert property (
    state_q == swdf_pkg::ST_RTO && mon_ok && !rto_done |=> !reset_n_q)
    else $error("Reset released before its timeout.");

  a_rto_exact: assert property (
    $rose(reset_n_q) |-> $past(state_q) == swdf_pkg::ST_RTO
    && $past(rto_done))
    else $error("Reset released at the wrong count.");

  a_long_first: assert property (
    en_rise |=> long_q)
    else $error("Long first period not armed.");

  a_restart_zero: assert property (
    $rose(reset_n_q) |-> wcnt_q == '0)
    else $error("Watchdog counter not zero at reset release.");

  a_late_kick_rst: assert property (
    cfg.windowed && timeout_hit && mon_ok |=> state_q == swdf_pkg::ST_RTO)
    else $error("Late kick not punished by reset.");

  a_half_window: assert property (
    cfg.windowed && !cfg.win_75 |-> closed == {4'h0, cfg.wd_period[23:1]})
    else $error("Closed window is not half the period.");

  a_most_window: assert property (
    cfg.windowed && cfg.win_75 |-> closed
    == {3'h0, cfg.wd_period} - {5'h00, cfg.wd_period[23:2]})
    else $error("Closed window is not three quarters of the period.");

  a_flag_kept: assert property (
    fail_q && !kick_fall |=> fail_q)
    else $error("Failover flag dropped without a good kick.");

  a_gate_idle: assert property (
    cfg.gated && !en_s2_q |=> wcnt_q == '0)
    else $error("Watchdog counted with the enable low.");

  a_long_clear: assert property (
    long_q && kick_fall && state_q == swdf_pkg::ST_RUN && mon_ok && wd_en
    && !en_rise && !early_kick |=> !long_q)
    else $error("Long first period kept after a good kick.");

endmodule // swdf_top

/* design/swdf_pkg.sv */
// Package for the supervisor watchdog with failover flag.
// Assumes one 100 MHz clock and a synchronous active-high reset.
package swdf_pkg;

  localparam int CNT_W = 24;
  localparam int WCNT_W = 27;
  localparam int FILT_W = 8;

  localparam int CLK_PERIOD_NS = 10;
  // Narrow kick pulses below this width are rejected.
  localparam int KICK_IGNORE_NS = 1000;
  // Kick pulses above this width must be seen; the filter is well inside.
  localparam int KICK_RECOG_NS = 6500;
  localparam int KICK_FILT_CYC =
    (KICK_IGNORE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [1:0] MISS_LIMIT_M1 = 2'h2;
  localparam logic [1:0] GOOD_LIMIT_M1 = 2'h2;
  localparam logic [1:0] CNT2_RST = 2'h0;
  localparam int LONG_SHIFT = 3;

  localparam logic RESET_N_RST = 1'h0;
  localparam logic FAILOVER_N_RST = 1'h1;
  localparam logic KICK_LVL_RST = 1'h1;

  typedef struct packed {
    logic [CNT_W-1:0] wd_period;
    logic [CNT_W-1:0] rst_period;
    logic windowed;
    logic win_75;
    logic gated;
  } swdf_cfg_t;

  typedef enum logic [2:0] {
    ST_HOLD = 3'b001,
    ST_RTO = 3'b010,
    ST_RUN = 3'b100
  } swdf_state_t;

endpackage

/* design/swdf_kick_filter.sv */
// Kick input synchroniser and pulse-width filter with falling edge pulse.
// Assumes the kick pin is asynchronous to clk.
`timescale 1ns/1ps
module swdf_kick_filter (
  input wire logic clk,
  input wire logic reset,
  input wire logic kick_in,
  output logic kick_fall
);

  logic s1_q, s2_q, lvl_q, lvl_d, fall_q, fall_d;
  logic [swdf_pkg::FILT_W-1:0] cnt_q, cnt_d;

  // A level must hold for the filter time before it is believed.
  always_comb
  begin
    lvl_d = lvl_q;
    fall_d = 1'b0;
    cnt_d = '0;
    if (s2_q != lvl_q)
    begin
      if (cnt_q == swdf_pkg::FILT_W'(swdf_pkg::KICK_FILT_CYC - 1))
      begin
        lvl_d = s2_q;
        fall_d = ~s2_q;
      end
      else
      begin
        cnt_d = cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s1_q <= swdf_pkg::KICK_LVL_RST;
      s2_q <= swdf_pkg::KICK_LVL_RST;
      lvl_q <= swdf_pkg::KICK_LVL_RST;
      fall_q <= 1'b0;
      cnt_q <= '0;
    end
    else
    begin
      s1_q <= kick_in;
      s2_q <= s1_q;
      lvl_q <= lvl_d;
      fall_q <= fall_d;
      cnt_q <= cnt_d;
    end
  end

  assign kick_fall = fall_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_fall_after_filter: assert property (
    fall_q |-> $past(cnt_q) == swdf_pkg::FILT_W'(swdf_pkg::KICK_FILT_CYC - 1))
    else $error("Kick edge passed before the filter time.");

endmodule // swdf_kick_filter

/* verif/swdf_mcu_model.sv */
// Behavioural controller that kicks the supervisor's watchdog pin.
// Assumes the supervisor's clock; kicking pauses while reset_n is low.
`timescale 1ns/1ps
module swdf_mcu_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [15:0] gap,
  input wire logic reset_n,
  output logic kick_in
);
  logic [15:0] cnt_q;
  initial kick_in = 1'h1;
  // The counter starts at the filter delay, so an accepted kick lands one
  // gap after release; a controller held in reset cannot kick.
  always @(posedge clk)
  begin
    if (!go || reset_n !== 1'h1)
    begin
      cnt_q <= 16'h0067;
      kick_in <= 1'h1;
    end
    else if (cnt_q == gap - 16'h0001)
    begin
      cnt_q <= 16'h0000;
      kick_in <= 1'h0;
    end
    else
    begin
      cnt_q <= cnt_q + 16'h0001;
      if (cnt_q == gap >> 1)
        kick_in <= 1'h1;
    end
  end
endmodule // swdf_mcu_model

/* verif/swdf_top_bench.sv */
// Self-checking bench for the supervisor watchdog.
// Assumes the controller model file and the design package are compiled.
`timescale 1ns/1ps
module swdf_top_bench;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic supply_monitor_in = 1'h1;
  logic wd_enable_in = 1'h0;
  logic go = 1'h0;
  logic armed = 1'h0;
  logic [15:0] gap = 16'h012C;
  logic [31:0] lfsr = 32'h0350;
  swdf_pkg::swdf_cfg_t cfg = '{24'h0001F4, 24'h000032, 1'h0, 1'h0, 1'h0};
  logic kick_in, reset_n, failover_n, r_prev, f_prev;
  logic q_r[$];
  logic q_f[$];
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  int n;

  swdf_mcu_model swdf_mcu_model_i (.clk(clk), .go(go), .gap(gap),
    .reset_n(reset_n), .kick_in(kick_in));
  swdf_top swdf_top_i (.clk(clk), .reset(reset), .kick_in(kick_in),
    .supply_monitor_in(supply_monitor_in), .wd_enable_in(wd_enable_in),
    .cfg(cfg), .reset_n(reset_n), .failover_n(failover_n));

  initial forever #5 clk = ~clk;

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
    input string what);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t %s: seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wt(input logic v, input int lim);
    n = 0;
    while (reset_n !== v && n < lim)
    begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic rst_dut(input swdf_pkg::swdf_cfg_t c);
    go <= 1'h0;
    @(posedge clk);
    if (reset_n === 1'h1)
      q_r.push_back(1'h0);
    reset <= 1'h1;
    cfg <= c;
    repeat (5) @(posedge clk);
    armed <= 1'h1;
    q_r.push_back(1'h1);
    reset <= 1'h0;
    wt(1'h1, 200);
    check(n >= 50 && n <= 60, 1, "reset hold");
  endtask

  // Every output change must match the oldest expected note.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_fail++;
      end_of_test();
    end
    if (armed && reset_n !== r_prev)
      check(reset_n,
        q_r.size() ? q_r.pop_front() : 1'bx, "reset_n");
    if (armed && failover_n !== f_prev)
      check(failover_n,
        q_f.size() ? q_f.pop_front() : 1'bx, "flag");
    r_prev <= reset_n;
    f_prev <= failover_n;
  end

  initial
  begin
    f_prev = 1'h1;
    rst_dut(cfg);
    lfsr = nxt(lfsr);
    gap <= 16'h012C + 16'(lfsr % 32'h64);
    go <= 1'h1;
    repeat (3000) @(posedge clk);
    go <= 1'h0;
    q_r = {1'h0, 1'h1, 1'h0, 1'h1, 1'h0};
    q_f.push_back(1'h0);
    for (int i = 0; i < 3; i++)
    begin
      wt(1'h0, 900);
      if (i > 0)
        check(n >= 498 && n <= 502, 1, "miss period");
      if (i < 2)
      begin
        wt(1'h1, 100);
        check(n >= 49 && n <= 51, 1, "fault hold");
      end
    end
    // Low supply hides the flag but the flag must come back afterwards.
    repeat (10) @(posedge clk);
    supply_monitor_in <= 1'h0;
    q_f.push_back(1'h1);
    repeat (200) @(posedge clk);
    q_f = {q_f, 1'h0, 1'h1};
    q_r.push_back(1'h1);
    supply_monitor_in <= 1'h1;
    go <= 1'h1;
    wt(1'h1, 100);
    check(n >= 51 && n <= 56, 1, "monitor hold");
    repeat (1500) @(posedge clk);
    check(failover_n, 1, "flag release");
    rst_dut('{24'h0001F4, 24'h000032, 1'h1, 1'h0, 1'h0});
    gap <= 16'h015E;
    go <= 1'h1;
    repeat (2500) @(posedge clk);
    check(reset_n, 1, "open window");
    go <= 1'h0;
    q_r = {q_r, 1'h0, 1'h1};
    wt(1'h0, 900);
    wt(1'h1, 100);
    check(n >= 49 && n <= 51, 1, "late hold");
    rst_dut('{24'h0001F4, 24'h000032, 1'h1, 1'h1, 1'h0});
    go <= 1'h1;
    q_r = {q_r, 1'h0, 1'h1};
    wt(1'h0, 600);
    check(n >= 349 && n <= 353, 1, "early kick");
    wt(1'h1, 100);
    check(n >= 49 && n <= 51, 1, "early hold");
    rst_dut('{24'h000000, 24'h000032, 1'h0, 1'h0, 1'h0});
    repeat (3000) @(posedge clk);
    check(reset_n, 1, "disabled");
    rst_dut('{24'h0001F4, 24'h000032, 1'h0, 1'h0, 1'h1});
    repeat (1000) @(posedge clk);
    wd_enable_in <= 1'h1;
    q_r = {q_r, 1'h0, 1'h1};
    wt(1'h0, 5000);
    check(n >= 3995 && n <= 4010, 1, "long period");
    wt(1'h1, 100);
    go <= 1'h1;
    repeat (1000) @(posedge clk);
    go <= 1'h0;
    q_r = {q_r, 1'h0, 1'h1};
    wt(1'h0, 900);
    check(n <= 510, 1, "normal period");
    wt(1'h1, 100);
    @(posedge clk);
    check(q_r.size() + q_f.size(), 0, "pending notes");
    end_of_test();
  end
endmodule // swdf_top_bench
